// >>> rtl/jio_map.vh
// Constants for the jump, OR, increment and shift execution block.
// Included by the datapath files; definitions only.
`ifndef JIO_MAP_VH
`define JIO_MAP_VH
`define JIO_OP_NONE      3'h0
`define JIO_OP_JUMP      3'h1
`define JIO_OP_OR_IMM    3'h2
`define JIO_OP_INC       3'h3
`define JIO_OP_OR_REG    3'h4
`define JIO_OP_SHL       3'h5
`define JIO_OP_SHR       3'h6
`define JIO_DEST_ACC     1'h0
`define JIO_DEST_FILE    1'h1
`define JIO_JUMP_CYCLES  2'h2
`define JIO_LATCH_HI     6
`define JIO_LATCH_LO     3
`define JIO_ACC_RESET    8'h00
`define JIO_PC_RESET     15'h0000
`endif

// >>> rtl/jio_alu.v
// Combinational result unit for the OR, increment and shift operations.
// Assumes the caller presents the operand fetched from the file register.
`timescale 1ns/1ps
`include "jio_map.vh"
module jio_alu (
  input  wire [2:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] lit,
  input  wire [7:0] file_val,
  input  wire       carry_in,
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        carry_we,
  output wire       zero
);
  always @* begin
    result    = acc;
    carry_out = carry_in;
    carry_we  = 1'b0;
    case (op)
      `JIO_OP_OR_IMM: result = acc | lit;                     // [RULE_04]
      `JIO_OP_INC:    result = file_val + 8'h01;              // [RULE_05]
      `JIO_OP_OR_REG: result = acc | file_val;                // [RULE_07]
      `JIO_OP_SHL: begin
        result    = {file_val[6:0], 1'b0};                    // [RULE_08]
        carry_out = file_val[7];                              // [RULE_08]
        carry_we  = 1'b1;
      end
      `JIO_OP_SHR: begin
        result    = {1'b0, file_val[7:1]};                    // [RULE_09]
        carry_out = file_val[0];                              // [RULE_09]
        carry_we  = 1'b1;
      end
      default: result = acc;
    endcase
  end
  assign zero = (result == 8'h00);                            // [RULE_10]
endmodule // jio_alu

// >>> rtl/jio_core.v
// Execution block: absolute jump, OR immediate/register, increment, zero-fill shifts.
// Assumes an external decoder issues one op per start pulse and waits for busy to fall.
// File register storage is 128 bytes of flip-flops, addressed by a 7-bit index.
//
// Summary of operation
// [RULE_01] The jump loads its 11-bit literal into program counter bits 10 to 0.
// [RULE_02] The jump fills program counter bits 14 to 11 from upper latch bits 6 to 3.
// [RULE_03] The jump is unconditional, takes two cycles and leaves every flag alone.
// [RULE_04] OR immediate ORs the accumulator with an 8-bit literal into the accumulator, touching only zero.
// [RULE_05] Increment adds one to the addressed file register, touching only zero.
// [RULE_06] For increment, OR register and the shifts, destination 0 writes the accumulator and 1 the file.
// [RULE_07] OR register ORs the accumulator with the file register, routed by destination, touching only zero.
// [RULE_08] Left shift sends bit 7 to carry, shifts the rest up and fills bit 0 with zero.
// [RULE_09] Right shift sends bit 0 to carry, shifts the rest down and fills bit 7 with zero.
// [RULE_10] Zero is set when the 8-bit result is zero and cleared otherwise.
`timescale 1ns/1ps
`include "jio_map.vh"
module jio_core (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        start,
  input  wire [2:0]  op,
  input  wire [10:0] jump_lit,
  input  wire [7:0]  imm_lit,
  input  wire [6:0]  file_addr,
  input  wire        dest,
  input  wire [6:0]  upper_jump_latch,
  output reg  [14:0] pc_q,
  output reg         pc_load_q,
  output reg  [7:0]  acc_q,
  output reg         zero_q,
  output reg         carry_q,
  output reg         busy_q,
  output reg         done_q
);
  localparam ST_IDLE = 1'b0;
  localparam ST_JUMP = 1'b1;

  // Sequencer state
  reg         state_q;
  reg         state_d;
  reg  [1:0]  cyc_q;
  reg  [1:0]  cyc_d;

  // Next values of the visible registers
  reg  [14:0] pc_d;
  reg         pc_load_d;
  reg  [7:0]  acc_d;
  reg         zero_d;
  reg         carry_d;
  reg         busy_d;
  reg         done_d;

  // File register storage and its read port
  reg  [7:0]  file_q [0:127];
  wire [7:0]  file_rd;

  // Result unit outputs
  wire [7:0]  result;
  wire        carry_out;
  wire        carry_we;
  wire        zero;

  // Decode helpers
  wire        is_jump;
  wire        is_alu;
  wire        file_op;
  wire        take;
  wire        acc_we;
  wire        file_we;
  wire [14:0] jump_target;

  assign is_jump = (op == `JIO_OP_JUMP);
  assign is_alu  = (op == `JIO_OP_OR_IMM) || (op == `JIO_OP_INC) || (op == `JIO_OP_OR_REG) ||
                   (op == `JIO_OP_SHL) || (op == `JIO_OP_SHR);
  assign file_op = is_alu && (op != `JIO_OP_OR_IMM);

  // A request is only taken while the sequencer is idle; starts during a jump are dropped
  assign take    = start && !busy_q && (state_q == ST_IDLE);

  // Immediate OR has no destination bit, so it always lands in the accumulator
  assign acc_we  = take && is_alu &&
                   ((op == `JIO_OP_OR_IMM) || (dest == `JIO_DEST_ACC));  // [RULE_04] [RULE_06]
  assign file_we = take && file_op && (dest == `JIO_DEST_FILE);          // [RULE_06]

  // One shared read port; the addressed byte feeds every file operation
  assign file_rd = file_q[file_addr];

  // Only latch bits 6 to 3 reach the counter; latch bits 2 to 0 are ignored
  assign jump_target = {upper_jump_latch[`JIO_LATCH_HI:`JIO_LATCH_LO], jump_lit}; // [RULE_01] [RULE_02]

  jio_alu u_alu (
    .op        (op),
    .acc       (acc_q),
    .lit       (imm_lit),
    .file_val  (file_rd),
    .carry_in  (carry_q),
    .result    (result),
    .carry_out (carry_out),
    .carry_we  (carry_we),
    .zero      (zero)
  );

  // File registers reset to zero so reads are defined from the start
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi = gi + 1) begin : g_file
      always @(posedge clk) begin
        if (sys_rst) begin
          file_q[gi] <= 8'h00;
        end else if (file_we && (file_addr == gi)) begin
          file_q[gi] <= result;                                         // [RULE_05] [RULE_06]
        end
      end
    end
  endgenerate

  // Next-state logic for the sequencer and all visible registers
  always @* begin
    state_d   = state_q;
    cyc_d     = cyc_q;
    pc_d      = pc_q;
    pc_load_d = 1'b0;
    acc_d     = acc_q;
    zero_d    = zero_q;
    carry_d   = carry_q;
    busy_d    = busy_q;
    done_d    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take && is_jump) begin
          // No condition is examined and no flag is written
          pc_d      = jump_target;                                      // [RULE_01] [RULE_02] [RULE_03]
          pc_load_d = 1'b1;
          busy_d    = 1'b1;
          cyc_d     = 2'h1;
          state_d   = ST_JUMP;
        end else if (take && is_alu) begin
          if (acc_we) begin
            acc_d = result;                                             // [RULE_04] [RULE_06]
          end
          // Every ALU op here affects zero; only the shifts touch carry
          zero_d = zero;                                                // [RULE_10]
          if (carry_we) begin
            carry_d = carry_out;                                        // [RULE_08] [RULE_09]
          end
          done_d = 1'b1;
        end
      end
      ST_JUMP: begin
        // Second cycle of the jump is the pipeline refill slot
        if (cyc_q == `JIO_JUMP_CYCLES - 2'h1) begin                     // [RULE_03]
          busy_d  = 1'b0;
          done_d  = 1'b1;
          cyc_d   = 2'h0;
          state_d = ST_IDLE;
        end else begin
          cyc_d = cyc_q + 2'h1;
        end
      end
      default: begin
        // Unreachable with a one-bit state; recover to idle anyway
        busy_d  = 1'b0;
        cyc_d   = 2'h0;
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cyc_q   <= 2'h0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q   <= cyc_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
    end
  end

  // Program counter and its load pulse
  always @(posedge clk) begin
    if (sys_rst) begin
      pc_q      <= `JIO_PC_RESET;
      pc_load_q <= 1'b0;
    end else begin
      pc_q      <= pc_d;
      pc_load_q <= pc_load_d;
    end
  end

  // Accumulator
  always @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= `JIO_ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Status flags; a jump leaves both untouched because the next values hold them
  always @(posedge clk) begin
    if (sys_rst) begin
      zero_q  <= 1'b0;
      carry_q <= 1'b0;
    end else begin
      zero_q  <= zero_d;
      carry_q <= carry_d;
    end
  end

  // Limitation: file writes and reads share one port, so a result is visible
  // to the next op one cycle later, which matches the one-op-per-cycle issue.
endmodule // jio_core

// >>> test/jio_core_monitor.sv
// Port checker for jio_core.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module jio_core_monitor (
  input wire clk, sys_rst, start, dest, pc_load_q, zero_q, carry_q, busy_q, done_q,
  input wire [2:0] op, input wire [10:0] jump_lit, input wire [7:0] imm_lit, acc_q,
  input wire [6:0] file_addr, upper_jump_latch, input wire [14:0] pc_q);
  wire g = start & ~busy_q;
  wire wa = op == 3'h2 || (op >= 3'h3 && op <= 3'h6 && !dest);
  reg [14:0] pe_q;
  // Captured every edge so the jump target is always one cycle old
  always @(posedge clk) pe_q <= {upper_jump_latch[6:3], jump_lit};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence jmp_end; busy_q ##1 (done_q && !busy_q); endsequence
  chk_jump_pc: assert property (g && op == 3'h1 |=> pc_q == pe_q && pc_load_q) else $error("jump pc");
  chk_jump_two: assert property (g && op == 3'h1 |=> jmp_end) else $error("jump length");
  chk_jump_flags: assert property (g && op == 3'h1 |=> $stable({zero_q, carry_q})[*2]) else $error("jump flags");
  chk_or_imm: assert property (g && op == 3'h2 |=> acc_q == ($past(acc_q) | $past(imm_lit)) && $stable(carry_q))
    else $error("or imm");
  chk_inc_done: assert property (g && op == 3'h3 |=> done_q && $stable(carry_q)) else $error("inc");
  chk_dest_file: assert property (g && op >= 3'h3 && op <= 3'h6 && dest |=> $stable(acc_q)) else $error("dest");
  chk_or_reg: assert property (g && op == 3'h4 && !dest |=> (acc_q & $past(acc_q)) == $past(acc_q)) else $error("or");
  chk_shl_fill: assert property (g && op == 3'h5 && !dest |=> !acc_q[0]) else $error("shl");
  chk_shr_fill: assert property (g && op == 3'h6 && !dest |=> !acc_q[7]) else $error("shr");
  chk_zero_flag: assert property (g && wa |=> zero_q == (acc_q == 8'h00)) else $error("zero");
endmodule // jio_core_monitor
bind jio_core jio_core_monitor chk_u (.*);

// >>> test/jio_core_test.sv
// Self-checking bench for jio_core.
// Assumes one-cycle ALU results and a two-cycle jump; the file is read back by shifts.
`timescale 1ns/1ps
module jio_core_test;
  reg clk = 0, sys_rst = 1, start = 0, dest = 0, ez = 0, ec = 0;
  reg [2:0] op = 0;
  reg [10:0] jump_lit = 0;
  reg [7:0] imm_lit = 0, ea = 0, r, mem [0:127];
  reg [6:0] file_addr = 0, upper_jump_latch = 0;
  wire [14:0] pc_q;
  wire [7:0] acc_q;
  wire pc_load_q, zero_q, carry_q, busy_q, done_q;
  integer errors = 0, n_checks = 0, i;
  jio_core dut_u (.*);
  initial forever #2 clk = ~clk;
  task chk(input [14:0] v, input [14:0] e); begin
    n_checks = n_checks + 1;
    if (v !== e) begin errors = errors + 1; $display("[FAIL] %0t seen %h want %h", $time, v, e); end
  end endtask
  task issue(input [2:0] o, input [6:0] a, input d, input [7:0] l); begin
    @(negedge clk); op = o; file_addr = a; dest = d; imm_lit = l; start = 1;
    @(negedge clk); start = 0;
  end endtask
  task do_op(input [2:0] o, input [6:0] a, input d, input [7:0] l); begin
    case (o)
      3'h2: r = ea | l;
      3'h3: r = mem[a] + 8'h01;
      3'h4: r = ea | mem[a];
      3'h5: begin ec = mem[a][7]; r = {mem[a][6:0], 1'b0}; end
      default: begin ec = mem[a][0]; r = {1'b0, mem[a][7:1]}; end
    endcase
    ez = r == 8'h00;
    if (o != 3'h2 && d) mem[a] = r; else ea = r;
    issue(o, a, d, l);
    chk(done_q, 1); chk(acc_q, ea); chk(zero_q, ez); chk(carry_q, ec);
  end endtask
  task t_alu; begin
    for (i = 0; i < 256; i = i + 1) do_op(3'h3, 7'h7f, 1, 0);
    do_op(3'h3, 7'h7f, 0, 0);
    do_op(3'h2, 0, 1, 8'h80);
    do_op(3'h4, 7'h7f, 1, 0);
    do_op(3'h4, 7'h05, 0, 0);
    do_op(3'h5, 7'h7f, 1, 0);
    do_op(3'h6, 7'h7f, 0, 0);
    do_op(3'h6, 7'h05, 0, 0);
    do_op(3'h5, 7'h7f, 0, 0);
    $display("t_alu end");
  end endtask
  task t_jump; begin
    jump_lit = 11'h7ff; upper_jump_latch = 7'h5a;
    issue(3'h1, 0, 0, 8'hff);
    chk(pc_q, 15'h5fff); chk(pc_load_q, 1); chk(busy_q, 1);
    op = 3'h2; start = 1;
    @(negedge clk); start = 0;
    chk(done_q, 1); chk(busy_q, 0); chk({acc_q, zero_q, carry_q}, {ea, ez, ec});
    issue(3'h0, 0, 0, 0); chk(done_q, 0);
    issue(3'h7, 0, 0, 0); chk(done_q, 0);
    $display("t_jump end");
  end endtask
  task finish_test; begin
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  end endtask
  initial begin
    for (i = 0; i < 128; i = i + 1) mem[i] = 0;
    repeat (8) @(negedge clk);
    sys_rst = 0;
    t_alu; t_jump; finish_test;
  end
endmodule // jio_core_test
